// *** include/exec_pkg.sv ***
// constants and carrier types shared by the execute slice
package exec_pkg;
	// opcodes
	localparam logic [7:0] OP_INC_ACC = 8'h04;
	localparam logic [7:0] OP_INC_DIR = 8'h05;
	localparam logic [7:0] OP_INC_IND = 8'h06;
	localparam logic [7:0] OP_INC_REG = 8'h08;
	localparam logic [7:0] OP_DECR_ACC = 8'h14;
	localparam logic [7:0] OP_DECR_DIR = 8'h15;
	localparam logic [7:0] OP_DECR_IND = 8'h16;
	localparam logic [7:0] OP_DECR_REG = 8'h18;
	localparam logic [7:0] OP_DIV = 8'h84;
	localparam logic [7:0] OP_DECBR_DIR = 8'hd5;
	localparam logic [7:0] OP_DECBR_REG = 8'hd8;
	localparam logic [7:0] OP_INC_DP = 8'ha3;
	localparam logic [7:0] OP_BR_BIT_SET = 8'h20;
	localparam logic [7:0] OP_BR_BIT_CLR = 8'h10;
	localparam logic [7:0] OP_BR_BIT_ZERO = 8'h30;
	localparam logic [7:0] OP_BR_CARRY = 8'h40;
	localparam logic [7:0] OP_BR_NO_CARRY = 8'h50;
	localparam logic [7:0] OP_BR_ACC_ZERO = 8'h60;
	localparam logic [7:0] OP_BR_ACC_NZ = 8'h70;
	localparam logic [7:0] OP_IDX_JUMP = 8'h73;
	localparam logic [7:0] OP_FAR_CALL = 8'h12;
	localparam logic [7:0] OP_FAR_JUMP = 8'h02;
	// masks for opcode groups
	localparam logic [7:0] MASK_IND = 8'hfe;
	localparam logic [7:0] MASK_REG = 8'hf8;
	// field positions
	localparam int DOWN_BIT = 4;
	localparam int IND_SEL_BIT = 0;
	// bit-addressable area base and byte limits
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// lengths in bytes
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	// reset values
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [7:0] RESET_SP = 8'h07;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_DATA_POINTER = 16'h0000;

	typedef enum logic {PH_EXEC, PH_SECOND} phase_type;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] acc;
		logic [7:0] b;
		logic [15:0] data_pointer;
		logic [7:0] sp;
		logic carry;
		logic overflow_flag;
	} arch_type;

	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} instr_type;

	typedef struct packed {
		logic valid;
		arch_type arch;
	} preset_type;

	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
	} ram_port_type;
endpackage

// *** src/step_unit.sv ***
// one-step incrementer or decrementer, wrapping at both ends
module step_unit #(
	parameter int WIDTH = 8
) (
	// operand
	input wire logic [WIDTH-1:0] value,
	input wire logic down,
	// result
	output logic [WIDTH-1:0] result
);
	// modular arithmetic gives the wrap for free; no carry is produced
	assign result = down ? WIDTH'(value - 1'b1) : WIDTH'(value + 1'b1);
endmodule // step_unit

// *** src/incdec_branch_exec.sv ***
// execute slice: increment, decrement, divide, conditional and far branches
// Behaviour
// - decrement lowers by one, zero becomes 255
// - decode decrement opcodes, one cycle, no flags
// - decrement wrap leaves carry unchanged
// - divide acc by b, quotient and remainder
// - divide clears carry, overflow flags zero divisor
// - decrement, branch when result nonzero, two cycles
// - increment raises by one, 255 wraps, no carry
// - decode increment opcodes, one cycle, no flags
// - data pointer increments sixteen bits, two cycles
// - branch when addressed bit is one
// - branch and clear bit when one
// - branch when addressed bit is zero
// - branch when carry is one
// - branch when carry is zero
// - branch when accumulator is zero
// - branch when accumulator is nonzero
// - jump to data pointer plus accumulator
// - far call pushes return low then high
// - far jump loads absolute target
module incdec_branch_exec
	import exec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// instruction issue
	input wire instr_type instr,
	// architectural preset
	input wire preset_type preset,
	// internal ram side port
	input wire ram_port_type ram_port,
	// state and status
	output arch_type arch_out,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [7:0] ram_rd_data
);
	typedef struct packed {
		phase_type phase;
		arch_type arch;
		logic [255:0][7:0] ram;
		logic [15:0] pc_pend;
		logic push_high;
		logic [7:0] ret_high;
		logic busy;
		logic done;
		logic illegal;
		logic [7:0] rd_data;
	} core_state_type;

	core_state_type st_r;
	core_state_type st_nxt;

	logic [7:0] opc;
	logic [7:0] b1;
	logic [7:0] b2;
	logic accept;
	logic grp_acc;
	logic grp_dir;
	logic grp_ind;
	logic grp_reg;
	logic step_op;
	logic decbr_dir;
	logic decbr_reg;
	logic decbr_op;
	logic three_byte;
	logic two_cycle;
	logic [1:0] len;
	logic [7:0] ind_ptr;
	logic [7:0] opnd_addr;
	logic [7:0] opnd_val;
	logic [7:0] step8_out;
	logic [15:0] step16_out;
	logic [7:0] bit_byte;
	logic [2:0] bit_idx;
	logic bit_val;
	logic [15:0] next_pc;
	logic [7:0] rel_byte;
	logic [15:0] rel_target;
	logic [15:0] abs_target;
	logic [15:0] idx_target;
	logic [7:0] sp_plus1;
	logic [7:0] quotient;
	logic [7:0] remainder;

	assign opc = instr.opcode;
	assign b1 = instr.byte1;
	assign b2 = instr.byte2;
	// preset and side-port writes win over issue; an instruction already in PH_SECOND still overwrites the preset pc with pc_pend
	assign accept = instr.valid && !st_r.busy && !preset.valid && !ram_port.wr_en;

	assign grp_acc = (opc == OP_INC_ACC) || (opc == OP_DECR_ACC);
	assign grp_dir = (opc == OP_INC_DIR) || (opc == OP_DECR_DIR);
	assign grp_ind = ((opc & MASK_IND) == OP_INC_IND) || ((opc & MASK_IND) == OP_DECR_IND);
	assign grp_reg = ((opc & MASK_REG) == OP_INC_REG) || ((opc & MASK_REG) == OP_DECR_REG);
	assign step_op = grp_acc || grp_dir || grp_ind || grp_reg;
	assign decbr_dir = (opc == OP_DECBR_DIR);
	assign decbr_reg = ((opc & MASK_REG) == OP_DECBR_REG);
	assign decbr_op = decbr_dir || decbr_reg;

	assign three_byte = decbr_dir || (opc == OP_BR_BIT_SET) || (opc == OP_BR_BIT_CLR) || (opc == OP_BR_BIT_ZERO)
		|| (opc == OP_FAR_CALL) || (opc == OP_FAR_JUMP);
	assign two_cycle = decbr_op || three_byte || (opc == OP_INC_DP) || (opc == OP_BR_CARRY)
		|| (opc == OP_BR_NO_CARRY) || (opc == OP_BR_ACC_ZERO) || (opc == OP_BR_ACC_NZ) || (opc == OP_IDX_JUMP);
	always_comb begin
		if (three_byte) begin
			len = LEN_THREE;
		end else if (grp_dir || decbr_reg || (opc == OP_BR_CARRY) || (opc == OP_BR_NO_CARRY)
			|| (opc == OP_BR_ACC_ZERO) || (opc == OP_BR_ACC_NZ)) begin
			len = LEN_TWO;
		end else begin
			len = LEN_ONE;
		end
	end

	// operand location: working registers sit in the lowest eight ram bytes
	assign ind_ptr = st_r.ram[{7'h00, opc[IND_SEL_BIT]}];
	assign opnd_addr = (grp_dir || decbr_dir) ? b1 : (grp_ind ? ind_ptr : {5'h00, opc[2:0]});
	assign opnd_val = grp_acc ? st_r.arch.acc : st_r.ram[opnd_addr];

	step_unit #(.WIDTH(8)) u_step8 (
		.value(opnd_val),
		.down(opc[DOWN_BIT] || decbr_op),
		.result(step8_out)
	);

	step_unit #(.WIDTH(16)) u_step16 (
		.value(st_r.arch.data_pointer),
		.down(1'b0),
		.result(step16_out)
	);

	// bits below the upper half live in the bit-addressable ram area
	assign bit_byte = b1[7] ? {b1[7:3], 3'h0} : 8'(BIT_AREA_BASE + {4'h0, b1[6:3]});
	assign bit_idx = b1[2:0];
	assign bit_val = st_r.ram[bit_byte][bit_idx];

	assign next_pc = 16'(st_r.arch.pc + {14'h0000, len});
	assign rel_byte = three_byte ? b2 : b1;
	assign rel_target = 16'(next_pc + {{8{rel_byte[7]}}, rel_byte});
	assign abs_target = {b1, b2};
	assign idx_target = 16'(st_r.arch.data_pointer + {8'h00, st_r.arch.acc});
	assign sp_plus1 = 8'(st_r.arch.sp + 8'h01);
	// a zero divisor bypasses the divider result: acc is kept and b stays zero
	assign quotient = (st_r.arch.b == BYTE_ZERO) ? st_r.arch.acc : st_r.arch.acc / st_r.arch.b;
	assign remainder = (st_r.arch.b == BYTE_ZERO) ? st_r.arch.b : st_r.arch.acc % st_r.arch.b;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.illegal = 1'b0;
		st_nxt.rd_data = st_r.ram[ram_port.addr];
		if (preset.valid) begin
			st_nxt.arch = preset.arch;
		end
		if (ram_port.wr_en) begin
			st_nxt.ram[ram_port.addr] = ram_port.wr_data;
		end
		unique case (st_r.phase)
			PH_EXEC: begin
				if (accept) begin
					st_nxt.pc_pend = next_pc;
					if (step_op) begin
						// flags untouched: no carry on either wrap
						if (grp_acc) begin
							st_nxt.arch.acc = step8_out;
						end else begin
							st_nxt.ram[opnd_addr] = step8_out;
						end
					end else if (decbr_op) begin
						st_nxt.ram[opnd_addr] = step8_out;
						if (step8_out != BYTE_ZERO) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_DIV) begin
						st_nxt.arch.carry = 1'b0;
						st_nxt.arch.overflow_flag = (st_r.arch.b == BYTE_ZERO);
						st_nxt.arch.acc = quotient;
						st_nxt.arch.b = remainder;
					end else if (opc == OP_INC_DP) begin
						st_nxt.arch.data_pointer = step16_out;
					end else if (opc == OP_BR_BIT_SET) begin
						if (bit_val) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_BIT_CLR) begin
						if (bit_val) begin
							st_nxt.ram[bit_byte][bit_idx] = 1'b0;
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_BIT_ZERO) begin
						if (!bit_val) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_CARRY) begin
						if (st_r.arch.carry) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_NO_CARRY) begin
						if (!st_r.arch.carry) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_ACC_ZERO) begin
						if (st_r.arch.acc == BYTE_ZERO) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_BR_ACC_NZ) begin
						if (st_r.arch.acc != BYTE_ZERO) begin
							st_nxt.pc_pend = rel_target;
						end
					end else if (opc == OP_IDX_JUMP) begin
						st_nxt.pc_pend = idx_target;
					end else if (opc == OP_FAR_CALL) begin
						st_nxt.arch.sp = sp_plus1;
						st_nxt.ram[sp_plus1] = next_pc[7:0];
						st_nxt.push_high = 1'b1;
						st_nxt.ret_high = next_pc[15:8];
						st_nxt.pc_pend = abs_target;
					end else if (opc == OP_FAR_JUMP) begin
						st_nxt.pc_pend = abs_target;
					end else begin
						// foreign opcodes are stepped over as one byte so issue never hangs
						st_nxt.illegal = 1'b1;
					end
					if (two_cycle) begin
						st_nxt.phase = PH_SECOND;
						st_nxt.busy = 1'b1;
					end else begin
						st_nxt.arch.pc = next_pc;
						st_nxt.done = 1'b1;
					end
				end
			end
			PH_SECOND: begin
				st_nxt.arch.pc = st_r.pc_pend;
				if (st_r.push_high) begin
					st_nxt.arch.sp = sp_plus1;
					st_nxt.ram[sp_plus1] = st_r.ret_high;
					st_nxt.push_high = 1'b0;
				end
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				st_nxt.phase = PH_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.phase <= PH_EXEC;
			st_r.arch.pc <= RESET_PC;
			st_r.arch.sp <= RESET_SP;
			st_r.arch.acc <= RESET_BYTE;
			st_r.arch.b <= RESET_BYTE;
			st_r.arch.data_pointer <= RESET_DATA_POINTER;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign arch_out = st_r.arch;
	assign busy = st_r.busy;
	assign done = st_r.done;
	assign illegal = st_r.illegal;
	assign ram_rd_data = st_r.rd_data;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_two_cycle;
		##1 busy ##1 (done && !busy);
	endsequence

	sequence s_one_cycle;
		##1 (done && !busy);
	endsequence

	chk_down_wrap_carry: assert property (
		accept && opc == OP_DECR_ACC && st_r.arch.acc == BYTE_ZERO
		|=> st_r.arch.acc == BYTE_MAX && st_r.arch.carry == $past(st_r.arch.carry))
		else $error("decrement of zero did not give 255 with carry kept");

	chk_inc_wrap_carry: assert property (
		accept && opc == OP_INC_ACC && st_r.arch.acc == BYTE_MAX
		|=> st_r.arch.acc == BYTE_ZERO && st_r.arch.carry == $past(st_r.arch.carry))
		else $error("increment of 255 did not wrap to zero with carry kept");

	chk_step_one_cycle: assert property (
		accept && step_op |-> s_one_cycle)
		else $error("increment or decrement did not finish in one cycle");

	chk_div_quotient: assert property (
		accept && opc == OP_DIV && st_r.arch.b != BYTE_ZERO
		|=> st_r.arch.acc == 8'($past(st_r.arch.acc) / $past(st_r.arch.b))
		&& st_r.arch.b == 8'($past(st_r.arch.acc) % $past(st_r.arch.b)) && done)
		else $error("divide result wrong");

	chk_div_flags: assert property (
		accept && opc == OP_DIV |=> !st_r.arch.carry
		&& st_r.arch.overflow_flag == ($past(st_r.arch.b) == BYTE_ZERO))
		else $error("divide flags wrong");

	chk_decbr_taken: assert property (
		accept && decbr_reg && opnd_val != 8'h01 |-> s_two_cycle
		##0 st_r.arch.pc == $past(rel_target, 2))
		else $error("decrement branch not taken to relative target");

	chk_decbr_fall: assert property (
		accept && decbr_op && opnd_val == 8'h01 |-> ##2 st_r.arch.pc == $past(next_pc, 2))
		else $error("decrement branch did not fall through at zero");

	chk_pointer_step: assert property (
		accept && opc == OP_INC_DP |-> s_two_cycle
		##0 st_r.arch.data_pointer == 16'($past(st_r.arch.data_pointer, 2) + 16'h0001))
		else $error("data pointer increment wrong");

	chk_bit_branch: assert property (
		accept && (opc == OP_BR_BIT_SET || opc == OP_BR_BIT_ZERO) |-> ##2
		st_r.arch.pc == (($past(bit_val, 2) == ($past(opc, 2) == OP_BR_BIT_SET)) ? $past(rel_target, 2)
		: $past(next_pc, 2)))
		else $error("bit branch went the wrong way");

	chk_bit_clear: assert property (
		accept && opc == OP_BR_BIT_CLR && bit_val
		|=> st_r.ram[$past(bit_byte)][$past(bit_idx)] == 1'b0 ##1 st_r.arch.pc == $past(rel_target, 2))
		else $error("bit not cleared or branch missed");

	chk_acc_branch: assert property (
		accept && (opc == OP_BR_ACC_ZERO || opc == OP_BR_ACC_NZ) && st_r.arch.acc != BYTE_ZERO
		|-> ##2 st_r.arch.pc == (($past(opc, 2) == OP_BR_ACC_NZ) ? $past(rel_target, 2) : $past(next_pc, 2)))
		else $error("accumulator branch wrong for nonzero accumulator");

	chk_carry_branch: assert property (
		accept && opc == OP_BR_CARRY && !st_r.arch.carry |-> ##2 st_r.arch.pc == $past(next_pc, 2))
		else $error("carry branch taken with carry clear");

	chk_far_call: assert property (
		accept && opc == OP_FAR_CALL |-> ##2 st_r.arch.sp == 8'($past(st_r.arch.sp, 2) + 8'h02)
		&& st_r.ram[st_r.arch.sp] == $past(next_pc[15:8], 2)
		&& st_r.arch.pc == $past(abs_target, 2))
		else $error("far call push or target wrong");

	chk_jumps: assert property (
		accept && (opc == OP_FAR_JUMP || opc == OP_IDX_JUMP) |-> ##2
		st_r.arch.pc == (($past(opc, 2) == OP_FAR_JUMP) ? $past(abs_target, 2) : $past(idx_target, 2)))
		else $error("unconditional jump target wrong");
endmodule // incdec_branch_exec

// *** testbench/incdec_branch_exec_tb.sv ***
// self-checking bench for the increment, decrement, divide and branch execute slice
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module incdec_branch_exec_tb
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// clock and reset
	logic clk;
	logic rst_n;
	// design side
	instr_type instr;
	preset_type preset;
	ram_port_type ram_port;
	arch_type arch_out;
	logic busy;
	logic done;
	logic illegal;
	logic [7:0] ram_rd_data;
	int num_errors = 0;
	int n_checks = 0;

	incdec_branch_exec u_incdec_branch_exec (
		.clk(clk),
		.rst_n(rst_n),
		.instr(instr),
		.preset(preset),
		.ram_port(ram_port),
		.arch_out(arch_out),
		.busy(busy),
		.done(done),
		.illegal(illegal),
		.ram_rd_data(ram_rd_data)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// load architectural state through the preset port
	task automatic set_state(input logic [15:0] p, input logic [7:0] a, b, input logic [15:0] dp,
		input logic [7:0] s, input logic c, o);
		@(posedge clk);
		preset <= '{1'b1, '{p, a, b, dp, s, c, o}};
		@(posedge clk);
		preset.valid <= 1'b0;
	endtask

	task automatic wram(input logic [7:0] a, d);
		@(posedge clk);
		ram_port <= '{1'b1, a, d};
		@(posedge clk);
		ram_port.wr_en <= 1'b0;
	endtask

	// read data lands on the edge that samples the address, one edge after it is driven
	task automatic rram(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		ram_port.addr <= a;
		@(posedge clk);
		#1;
		d = ram_rd_data;
	endtask

	// issue one instruction and count cycles until done; bounded so a hang cannot stall here
	task automatic issue(input logic [7:0] op, b1, b2, output int cyc);
		@(posedge clk);
		instr <= '{1'b1, op, b1, b2};
		@(posedge clk);
		instr.valid <= 1'b0;
		cyc = 0;
		repeat (4) begin
			#1;
			cyc++;
			if (done === 1'b1)
				break;
			@(posedge clk);
		end
	endtask

	task automatic t_incdec();
		logic [7:0] op[6] = '{8'h15, 8'h05, 8'h16, 8'h07, 8'h1a, 8'h0f};
		logic [7:0] ad[6] = '{8'h40, 8'h41, 8'h60, 8'h61, 8'h02, 8'h07};
		logic [7:0] iv[6] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
		logic [15:0] epc;
		logic [7:0] rd;
		logic [7:0] ex;
		int cyc;
		set_state(16'h0100, 8'h00, 8'h00, 16'h0000, 8'h30, 1'b1, 1'b1);
		wram(8'h00, 8'h60);
		wram(8'h01, 8'h61);
		issue(OP_DECR_ACC, 8'h00, 8'h00, cyc);
		`CHK("decr acc", 8'hff, arch_out.acc)
		`CHK("decr cycles", 1, cyc)
		issue(OP_INC_ACC, 8'h00, 8'h00, cyc);
		`CHK("inc acc", 8'h00, arch_out.acc)
		epc = 16'h0102;
		for (int i = 0; i < 6; i++) begin
			wram(ad[i], iv[i]);
			issue(op[i], ad[i], 8'h00, cyc);
			epc = epc + ((op[i][3:0] == 4'h5) ? 16'h0002 : 16'h0001);
			ex = op[i][4] ? iv[i] - 8'h01 : iv[i] + 8'h01;
			rram(ad[i], rd);
			`CHK("incdec operand", ex, rd)
			`CHK("incdec pc", epc, arch_out.pc)
			`CHK("incdec cycles", 1, cyc)
		end
		`CHK("incdec flags", 2'b11, {arch_out.carry, arch_out.overflow_flag})
	endtask

	task automatic t_div();
		int cyc;
		set_state(16'h0200, 8'hc8, 8'h0b, 16'h0000, 8'h07, 1'b1, 1'b1);
		issue(OP_DIV, 8'h00, 8'h00, cyc);
		`CHK("div quotient", 8'h12, arch_out.acc)
		`CHK("div remainder", 8'h02, arch_out.b)
		`CHK("div cycles", 1, cyc)
		`CHK("div flags", 2'b00, {arch_out.carry, arch_out.overflow_flag})
		set_state(16'h0200, 8'h37, 8'h00, 16'h0000, 8'h07, 1'b1, 1'b0);
		issue(OP_DIV, 8'h00, 8'h00, cyc);
		`CHK("div zero flags", 2'b01, {arch_out.carry, arch_out.overflow_flag})
	endtask

	task automatic t_decbr();
		logic [7:0] rd;
		int cyc;
		set_state(16'h0300, 8'h00, 8'h00, 16'h0000, 8'h07, 1'b1, 1'b0);
		wram(8'h05, 8'h02);
		issue(8'hdd, 8'hfc, 8'h00, cyc);
		`CHK("decbr taken pc", 16'h02fe, arch_out.pc)
		`CHK("decbr cycles", 2, cyc)
		issue(8'hdd, 8'hfc, 8'h00, cyc);
		`CHK("decbr fall pc", 16'h0300, arch_out.pc)
		rram(8'h05, rd);
		`CHK("decbr reg", 8'h00, rd)
		wram(8'h30, 8'h00);
		issue(OP_DECBR_DIR, 8'h30, 8'h10, cyc);
		rram(8'h30, rd);
		`CHK("decbr wrap", 8'hff, rd)
		`CHK("decbr direct pc", 16'h0313, arch_out.pc)
		`CHK("decbr carry", 1'b1, arch_out.carry)
	endtask

	task automatic t_dp_step();
		int cyc;
		set_state(16'h0400, 8'h00, 8'h00, 16'hffff, 8'h07, 1'b0, 1'b0);
		issue(OP_INC_DP, 8'h00, 8'h00, cyc);
		`CHK("pointer wrap", 16'h0000, arch_out.data_pointer)
		`CHK("pointer carry", 1'b0, arch_out.carry)
		`CHK("pointer cycles", 2, cyc)
		`CHK("pointer step pc", 16'h0401, arch_out.pc)
	endtask

	// bit 0x0a lives in byte 0x21, bit 2; the clear by the first OP_BR_BIT_CLR flips later outcomes
	task automatic t_bit();
		logic [7:0] op[6] = '{OP_BR_BIT_SET, OP_BR_BIT_ZERO, OP_BR_BIT_CLR, OP_BR_BIT_CLR, OP_BR_BIT_ZERO, OP_BR_BIT_SET};
		logic tk[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic [15:0] epc;
		logic [7:0] rd;
		int cyc;
		set_state(16'h0500, 8'h00, 8'h00, 16'h0000, 8'h07, 1'b0, 1'b0);
		wram(8'h21, 8'h04);
		epc = 16'h0500;
		for (int i = 0; i < 6; i++) begin
			issue(op[i], 8'h0a, 8'h08, cyc);
			epc = epc + 16'h0003 + (tk[i] ? 16'h0008 : 16'h0000);
			`CHK("bit branch pc", epc, arch_out.pc)
		end
		rram(8'h21, rd);
		`CHK("bit cleared", 8'h00, rd)
	endtask

	task automatic t_cond();
		logic [7:0] op[4] = '{OP_BR_CARRY, OP_BR_NO_CARRY, OP_BR_ACC_ZERO, OP_BR_ACC_NZ};
		logic [15:0] epc;
		logic tk;
		int cyc;
		for (int k = 0; k < 2; k++) begin
			set_state(16'h0600, k ? 8'h05 : 8'h00, 8'h00, 16'h0000, 8'h07, k ? 1'b0 : 1'b1, 1'b0);
			epc = 16'h0600;
			for (int i = 0; i < 4; i++) begin
				issue(op[i], 8'h80, 8'h00, cyc);
				tk = ((i % 2) == 0) ^ (k == 1);
				epc = epc + 16'h0002 + (tk ? 16'hff80 : 16'h0000);
				`CHK("cond branch pc", epc, arch_out.pc)
				`CHK("cond cycles", 2, cyc)
			end
		end
	endtask

	task automatic t_jumps();
		logic [7:0] rd;
		int cyc;
		set_state(16'h0700, 8'hf0, 8'h00, 16'h1234, 8'h07, 1'b0, 1'b0);
		issue(OP_IDX_JUMP, 8'h00, 8'h00, cyc);
		`CHK("indexed jump", 16'h1324, arch_out.pc)
		issue(OP_FAR_JUMP, 8'h43, 8'h21, cyc);
		`CHK("far jump", 16'h4321, arch_out.pc)
		issue(OP_FAR_CALL, 8'hab, 8'hcd, cyc);
		`CHK("call pc", 16'habcd, arch_out.pc)
		`CHK("call sp", 8'h09, arch_out.sp)
		`CHK("call cycles", 2, cyc)
		rram(8'h08, rd);
		`CHK("call low byte", 8'h24, rd)
		rram(8'h09, rd);
		`CHK("call high byte", 8'h43, rd)
	endtask

	// an opcode outside the slice pulses illegal and steps one byte; busy marks the second cycle
	task automatic t_foreign();
		int cyc;
		set_state(16'h0800, 8'h00, 8'h00, 16'h0000, 8'h07, 1'b0, 1'b0);
		issue(8'ha5, 8'h00, 8'h00, cyc);
		`CHK("foreign illegal", 1'b1, illegal)
		`CHK("foreign pc", 16'h0801, arch_out.pc)
		@(posedge clk);
		instr <= '{1'b1, OP_FAR_JUMP, 8'h12, 8'h34};
		@(posedge clk);
		instr.valid <= 1'b0;
		#1;
		`CHK("jump busy", 2'b10, {busy, done})
		`CHK("jump pc held", 16'h0801, arch_out.pc)
		@(posedge clk);
		#1;
		`CHK("jump done", 2'b01, {busy, done})
		`CHK("jump pc", 16'h1234, arch_out.pc)
	endtask

	// whole run is under two hundred cycles; this bound only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		instr = '0;
		preset = '0;
		ram_port = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_incdec();
		t_div();
		t_decbr();
		t_dp_step();
		t_bit();
		t_cond();
		t_jumps();
		t_foreign();
		print_verdict();
	end
endmodule // incdec_branch_exec_tb
